// >>> logic/bps_pkg.sv
/*
 * Shared constants and types of the BCD preset SDO sender.
 * Assumes a 40 MHz system clock and a frame-level CAN controller beside the block.
 */
package bps_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TIMEOUT_MS = 2500;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int unsigned BLINK_MS = 250;
    localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int unsigned PAUSE_MS = 1000;
    localparam int unsigned PAUSE_CYC = PAUSE_MS * (CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////////////
    // SDO frame constants
    localparam logic [10:0] REQ_ID_BASE = 11'h640;
    localparam logic [10:0] RESP_ID_BASE = 11'h5c0;
    localparam logic [7:0] CS_WRITE_REQ = 8'h23;
    localparam logic [7:0] CS_WRITE_RESP = 8'h60;
    localparam logic [7:0] CS_ABORT = 8'h80;
    localparam logic [3:0] SDO_DLC = 4'h8;
    // Register selection 0..3 -> object index and sub-index
    localparam logic [3:0][15:0] SEL_INDEX = {16'h5e25, 16'h5e25, 16'h5e26, 16'h5e26};
    localparam logic [3:0][7:0] SEL_SUB = {8'h02, 8'h01, 8'h02, 8'h01};
    // Store to non-volatile memory, remote_store_code
    localparam logic [15:0] STORE_INDEX = 16'h5ffc;
    localparam logic [7:0] STORE_SUB = 8'h00;
    localparam logic [31:0] STORE_VALUE = 32'h0000_0001;

    ////////////////////////////////////////////////////////////////////////////////
    // Rear switch fields
    localparam int unsigned DIL8_NODE_LSB = 0;
    localparam int unsigned DIL8_STORE_BIT = 5;
    localparam int unsigned DIL8_SEL_LSB = 6;
    localparam int unsigned DIL4_RATE_LSB = 0;
    localparam int unsigned DIL4_SIGN_BIT = 3;
    localparam logic [2:0] RATE_INVALID = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Error codes
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_CONFIG = 3'h1;
    localparam logic [2:0] ERR_TIMEOUT = 3'h2;
    localparam logic [2:0] ERR_ABORT = 3'h3;
    localparam logic [2:0] ERR_PROTO = 3'h4;
    localparam logic [2:0] ERR_BCD = 3'h5;
    localparam logic [2:0] ERR_BUS = 3'h6;
    localparam logic [2:0] ERR_STORE = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Register port
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MASK = 8'h04;
    localparam logic [7:0] REG_CONTROL = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;
    localparam logic [7:0] REG_VALUE = 8'h10;
    localparam int unsigned STATUS_W = 3;
    localparam int unsigned EV_DONE = 0;
    localparam int unsigned EV_ERROR = 1;
    localparam int unsigned EV_STORED = 2;
    localparam logic [2:0] MASK_RST = 3'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [10:0] id;
        logic [3:0] dlc;
        logic [7:0][7:0] data;
    } bps_frame_t;

    typedef struct packed {
        logic [2:0] bitrate;
        logic sign_mode;
        logic [4:0] node;
        logic store;
        logic [1:0] regsel;
    } bps_cfg_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SEND = 5'b00010,
        ST_WAIT = 5'b00100,
        ST_SEND_STORE = 5'b01000,
        ST_WAIT_STORE = 5'b10000
    } bps_state_t;

endpackage

// >>> logic/bps_led_blinker.sv
/*
 * Front LED driver: steady light without error, else a burst of blinks
 * equal to the error code followed by a pause.
 * Assumes the error code is a registered level in the same clock domain.
 */
module bps_led_blinker
    import bps_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC,
    parameter int unsigned PAUSE_CYCLES = PAUSE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [2:0] err_code,
    output logic led_on
);

    logic [31:0] cnt_q;
    logic [3:0] half_q;
    logic led_q;

    // Half-period sequencer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 32'h0;
            half_q <= 4'h0;
            led_q <= 1'b0;
        end else if (err_code == ERR_NONE) begin
            cnt_q <= 32'h0;
            half_q <= 4'h0;
            led_q <= 1'b1;
        end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
        end else if (half_q < {err_code, 1'b0}) begin
            led_q <= ~half_q[0];
            cnt_q <= BLINK_CYCLES - 1;
            half_q <= half_q + 4'h1;
        end else begin
            led_q <= 1'b0;
            cnt_q <= PAUSE_CYCLES - 1;
            half_q <= 4'h0;
        end
    end

    assign led_on = led_q;

endmodule

// >>> logic/bps_sender.sv
/*
 * BCD preset SDO sender: samples rear switches once after reset, turns the
 * thumbwheel value into a 32-bit SDO expedited write and waits for the answer.
 * Assumes a frame-level CAN controller (tx/rx frame ports, bit rate select)
 * and synchronous, already debounced button and switch inputs.
 */
// Local design decisions: the address map and the plain strobed port.
module bps_sender
    import bps_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
    parameter int unsigned BLINK_CYCLES = BLINK_CYC,
    parameter int unsigned PAUSE_CYCLES = PAUSE_CYC
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [3:0] dil4,
    input wire logic [7:0] dil8,
    input wire logic signed_variant_option,
    input wire logic enter_btn,
    input wire logic [23:0] thumb_bcd,
    output bps_frame_t tx_frame,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire bps_frame_t rx_frame,
    input wire logic rx_valid,
    input wire logic can_fault,
    output logic [2:0] can_bitrate_sel,
    output logic led_on,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [31:0] reg_rdata,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    bps_cfg_t cfg_q;
    logic init_done_q;
    logic cfg_bad;
    logic [2:0] err_q;
    bps_state_t state_q;
    bps_state_t state_d;
    bps_frame_t tx_frame_q;
    logic [31:0] value_q;
    logic [31:0] tmo_q;
    logic btn_q;
    logic btn_rise;
    logic fault_q;
    logic soft_start;
    logic start_req;
    logic [5:0] dig_bad;
    logic bcd_bad;
    logic [31:0] conv_value;
    logic resp_hit;
    logic tmo_hit;
    logic ev_err;
    logic [2:0] ev_code;
    logic ev_done;
    logic ev_stored;
    logic [STATUS_W-1:0] status_q;
    logic [STATUS_W-1:0] mask_q;
    logic [STATUS_W-1:0] status_set;
    logic [STATUS_W-1:0] status_clr;
    logic [31:0] rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Expedited 4-byte SDO write request
    function automatic bps_frame_t build_req(input logic [4:0] node, input logic [15:0] idx,
                                             input logic [7:0] sub, input logic [31:0] val);
        bps_frame_t f;
        f.id = REQ_ID_BASE + {6'h00, node};
        f.dlc = SDO_DLC;
        f.data[0] = CS_WRITE_REQ;
        f.data[1] = idx[7:0];
        f.data[2] = idx[15:8];
        f.data[3] = sub;
        f.data[4] = val[7:0];
        f.data[5] = val[15:8];
        f.data[6] = val[23:16];
        f.data[7] = val[31:24];
        return f;
    endfunction

    // BCD to binary; in sign mode the top digit is a sign, nonzero meaning minus
    function automatic logic [31:0] bcd_conv(input logic [23:0] bcd, input logic sign_mode);
        logic [31:0] acc;
        acc = 32'h0;
        for (int i = 5; i >= 0; i--) begin
            if (!(sign_mode && i == 5)) begin
                acc = acc * 32'd10 + {28'h0, bcd[i*4 +: 4]};
            end
        end
        if (sign_mode && bcd[23:20] != 4'h0) begin
            acc = 32'h0 - acc;
        end
        return acc;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Switch sampling at the first edge after reset release
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_q <= '0;
            init_done_q <= 1'b0;
        end else if (!init_done_q) begin
            cfg_q.bitrate <= dil4[DIL4_RATE_LSB +: 3];
            cfg_q.sign_mode <= dil4[DIL4_SIGN_BIT];
            cfg_q.node <= dil8[DIL8_NODE_LSB +: 5];
            cfg_q.store <= dil8[DIL8_STORE_BIT];
            cfg_q.regsel <= dil8[DIL8_SEL_LSB +: 2];
            init_done_q <= 1'b1;
        end
    end

    // Unsupported rate code or signed unit without slider 4
    assign cfg_bad = !init_done_q &&
                     ((dil4[DIL4_RATE_LSB +: 3] == RATE_INVALID) ||
                      (signed_variant_option && !dil4[DIL4_SIGN_BIT]));
    assign can_bitrate_sel = cfg_q.bitrate;

    ////////////////////////////////////////////////////////////////////////////////
    // Input edges and start request
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            btn_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            btn_q <= enter_btn;
            fault_q <= can_fault;
        end
    end

    assign btn_rise = enter_btn && !btn_q;
    assign soft_start = reg_we && reg_addr == REG_CONTROL && reg_wdata[0];
    assign start_req = init_done_q && err_q == ERR_NONE && state_q == ST_IDLE &&
                       (btn_rise || soft_start);

    // Per-digit range check; the sign digit may hold any code
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_dig
            assign dig_bad[g] = (thumb_bcd[g*4 +: 4] > 4'h9) && !(g == 5 && cfg_q.sign_mode);
        end
    endgenerate
    assign bcd_bad = |dig_bad;
    assign conv_value = bcd_conv(thumb_bcd, cfg_q.sign_mode);

    ////////////////////////////////////////////////////////////////////////////////
    // Response matching: only the SDO answer of our node, index and sub-index
    assign resp_hit = rx_valid && rx_frame.id == RESP_ID_BASE + {6'h00, cfg_q.node} &&
                      rx_frame.data[1] == tx_frame_q.data[1] &&
                      rx_frame.data[2] == tx_frame_q.data[2] &&
                      rx_frame.data[3] == tx_frame_q.data[3];
    assign tmo_hit = tmo_q == TIMEOUT_CYCLES - 1;

    // Transaction sequencer decisions
    always_comb begin
        state_d = state_q;
        ev_err = 1'b0;
        ev_code = ERR_NONE;
        ev_done = 1'b0;
        ev_stored = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (start_req) begin
                    if (bcd_bad) begin
                        ev_err = 1'b1;
                        ev_code = ERR_BCD;
                    end else begin
                        state_d = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (tx_ready) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (resp_hit) begin
                    if (rx_frame.data[0] == CS_WRITE_RESP) begin
                        ev_done = 1'b1;
                        state_d = cfg_q.store ? ST_SEND_STORE : ST_IDLE;
                    end else begin
                        ev_err = 1'b1;
                        ev_code = (rx_frame.data[0] == CS_ABORT) ? ERR_ABORT : ERR_PROTO;
                        state_d = ST_IDLE;
                    end
                end else if (tmo_hit) begin
                    ev_err = 1'b1;
                    ev_code = ERR_TIMEOUT;
                    state_d = ST_IDLE;
                end
            end
            ST_SEND_STORE: begin
                if (tx_ready) begin
                    state_d = ST_WAIT_STORE;
                end
            end
            ST_WAIT_STORE: begin
                if (resp_hit && rx_frame.data[0] == CS_WRITE_RESP) begin
                    ev_stored = 1'b1;
                    state_d = ST_IDLE;
                end else if (resp_hit || tmo_hit) begin
                    ev_err = 1'b1;
                    ev_code = ERR_STORE;
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // A pending fault drops any transaction in flight
        if (err_q != ERR_NONE && state_q != ST_IDLE) begin
            state_d = ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Request frame, latched value and response timer
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_frame_q <= '0;
            value_q <= 32'h0;
            tmo_q <= 32'h0;
        end else begin
            if (state_q == ST_IDLE && state_d == ST_SEND) begin
                value_q <= conv_value;
                tx_frame_q <= build_req(cfg_q.node, SEL_INDEX[cfg_q.regsel],
                                        SEL_SUB[cfg_q.regsel], conv_value);
            end else if (state_q == ST_WAIT && state_d == ST_SEND_STORE) begin
                tx_frame_q <= build_req(cfg_q.node, STORE_INDEX, STORE_SUB,
                                        STORE_VALUE);
            end
            if (state_q == ST_WAIT || state_q == ST_WAIT_STORE) begin
                tmo_q <= tmo_q + 32'h1;
            end else begin
                tmo_q <= 32'h0;
            end
        end
    end

    assign tx_frame = tx_frame_q;
    assign tx_valid = state_q == ST_SEND || state_q == ST_SEND_STORE;

    ////////////////////////////////////////////////////////////////////////////////
    // Error condition: config error sticks, others cleared by the button
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            err_q <= ERR_NONE;
        end else if (cfg_bad) begin
            err_q <= ERR_CONFIG;
        end else if (err_q == ERR_NONE) begin
            if (ev_err) begin
                err_q <= ev_code;
            end else if (init_done_q && can_fault && !fault_q) begin
                err_q <= ERR_BUS;
            end
        end else if (err_q != ERR_CONFIG && btn_rise) begin
            err_q <= ERR_NONE;
        end
    end

    // Front LED
    bps_led_blinker #(
        .BLINK_CYCLES(BLINK_CYCLES),
        .PAUSE_CYCLES(PAUSE_CYCLES)
    ) u_led (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .err_code(err_q),
        .led_on(led_on)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register port: sticky status, mask, read data one cycle later
    assign status_set = {ev_stored, (err_q == ERR_NONE) &&
                         (cfg_bad || ev_err || (init_done_q && can_fault && !fault_q)), ev_done};
    assign status_clr = (reg_we && reg_addr == REG_STATUS) ? reg_wdata[STATUS_W-1:0] : '0;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~status_clr) | status_set;
        end
    end

    // Interrupt mask
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            mask_q <= MASK_RST;
        end else if (reg_we && reg_addr == REG_MASK) begin
            mask_q <= reg_wdata[STATUS_W-1:0];
        end
    end

    // Read mux; unmapped addresses read zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 32'h0;
        end else if (reg_re) begin
            case (reg_addr)
                REG_STATUS: rdata_q <= {29'h0, status_q};
                REG_MASK: rdata_q <= {29'h0, mask_q};
                REG_STATE: rdata_q <= {8'h00, cfg_q, init_done_q, state_q, 3'h0, err_q};
                REG_VALUE: rdata_q <= value_q;
                default: rdata_q <= 32'h0;
            endcase
        end else begin
            rdata_q <= 32'h0;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = |(status_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    cfg_frozen_a: assert property (
        init_done_q && $past(init_done_q) |-> $stable(cfg_q))
        else $error("switch settings changed after initialisation");

    req_id_a: assert property (
        tx_valid |-> tx_frame.id == REQ_ID_BASE + {6'h00, cfg_q.node})
        else $error("request identifier does not match node address");

    store_follow_a: assert property (
        state_q == ST_WAIT && ev_done && cfg_q.store |=> state_q == ST_SEND_STORE
        && tx_frame.data[2] == STORE_INDEX[15:8] && tx_frame.data[1] == STORE_INDEX[7:0])
        else $error("store request did not follow successful write");

    sel_index_a: assert property (
        state_q == ST_SEND |-> tx_frame.data[1] == SEL_INDEX[cfg_q.regsel][7:0]
        && tx_frame.data[3] == SEL_SUB[cfg_q.regsel])
        else $error("index or sub-index does not follow selection");

    resp_timeout_a: assert property (
        state_q == ST_WAIT && tmo_hit && !resp_hit && err_q == ERR_NONE
        |=> state_q == ST_IDLE && err_q == ERR_TIMEOUT)
        else $error("timeout not reported");

    req_cmd_a: assert property (
        tx_valid |-> tx_frame.data[0] == CS_WRITE_REQ && tx_frame.dlc == SDO_DLC)
        else $error("bad command specifier or length");

    value_bytes_a: assert property (
        state_q == ST_SEND |-> {tx_frame.data[7], tx_frame.data[6],
        tx_frame.data[5], tx_frame.data[4]} == value_q)
        else $error("value bytes out of order");

    config_sticky_a: assert property (
        err_q == ERR_CONFIG |=> err_q == ERR_CONFIG)
        else $error("configuration error was cleared");

    led_steady_a: assert property (
        (init_done_q && err_q == ERR_NONE)[*2] |-> led_on)
        else $error("LED not steady without error");

    press_start_a: assert property (
        start_req && !bcd_bad |=> state_q == ST_SEND ##0 value_q == $past(conv_value))
        else $error("button press did not start a write");

endmodule

// >>> testbench/bps_node_model.sv
/*
 * Remote node model: takes each SDO request and answers it as told by mode.
 * Assumes the sender's tx handshake and one-cycle rx pulses on sys_clk.
 */
module bps_node_model
    import bps_pkg::*;
(
    input wire logic sys_clk,
    input wire bps_frame_t tx_frame,
    input wire logic tx_valid,
    input wire logic [1:0] mode,
    output logic tx_ready,
    output bps_frame_t rx_frame,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    bps_frame_t f;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode 0 answers, 1 stays silent, 2 aborts; bus lines scrambled when idle
    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_frame = '1;
        forever begin
            @(posedge sys_clk);
            #1;
            if (tx_valid === 1'b1) begin
                f = tx_frame;
                repeat (2) @(posedge sys_clk);
                tx_ready <= 1'b1;
                @(posedge sys_clk);
                tx_ready <= 1'b0;
                repeat (3) @(posedge sys_clk);
                if (mode != 2'h1) begin
                    // Build the answer first so the frame is driven once per step
                    f.id = RESP_ID_BASE + (f.id - REQ_ID_BASE);
                    f.data[0] = (mode == 2'h2) ? CS_ABORT : CS_WRITE_RESP;
                    rx_frame <= f;
                    rx_valid <= 1'b1;
                    @(posedge sys_clk);
                    rx_valid <= 1'b0;
                    rx_frame <= ~f;
                end
            end
        end
    end
endmodule

// >>> testbench/bps_sender_bench.sv
/*
 * Self-checking bench of the BCD preset SDO sender with a remote node model.
 * Assumes short timeout and blink parameters; one 40 MHz clock.
 */
module bps_sender_bench
    import bps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] dil4 = 4'h3;
    logic [7:0] dil8 = 8'h47;
    logic signed_variant_option = 1'b0;
    logic enter_btn = 1'b0;
    logic [23:0] thumb_bcd = 24'h0;
    logic [1:0] mode = 2'h0;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic can_fault = 1'b0;
    bps_frame_t tx_frame, rx_frame, f;
    logic tx_valid, tx_ready, rx_valid, led_on, irq;
    logic [2:0] can_bitrate_sel;
    logic [31:0] reg_rdata, d;
    int n_fail = 0;
    int compares = 0;
    int lows;

    always #12.5 sys_clk = ~sys_clk;

    bps_sender #(.TIMEOUT_CYCLES(200), .BLINK_CYCLES(4), .PAUSE_CYCLES(8)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .dil4(dil4), .dil8(dil8),
        .signed_variant_option(signed_variant_option), .enter_btn(enter_btn),
        .thumb_bcd(thumb_bcd), .tx_frame(tx_frame), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_frame(rx_frame), .rx_valid(rx_valid), .can_fault(can_fault),
        .can_bitrate_sel(can_bitrate_sel), .led_on(led_on), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .irq(irq));

    bps_node_model node (.sys_clk(sys_clk), .tx_frame(tx_frame), .tx_valid(tx_valid),
        .mode(mode), .tx_ready(tx_ready), .rx_frame(rx_frame), .rx_valid(rx_valid));

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Reset with new switch settings, then wait until presses are allowed
    task automatic do_reset(input logic [3:0] s4, input logic [7:0] s8, input logic strap);
        sys_rst <= 1'b1;
        dil4 <= s4;
        dil8 <= s8;
        signed_variant_option <= strap;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
        @(posedge sys_clk);
    endtask

    task automatic press;
        enter_btn <= 1'b1;
        @(posedge sys_clk);
        enter_btn <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Capture the next request frame and compare its identifier, command, index, sub-index and value
    task automatic chk_tx(input logic [10:0] id, input logic [15:0] idx,
                          input logic [7:0] sub, input logic [31:0] val);
        for (int i = 0; i < 50 && tx_valid !== 1'b1; i++) @(posedge sys_clk) #1;
        f = tx_frame;
        check(tx_valid, 1'b1);
        check(f.id, id);
        check(f.data[0], CS_WRITE_REQ);
        check({f.data[2], f.data[1], f.data[3]}, {idx, sub});
        check({f.data[7], f.data[6], f.data[5], f.data[4]}, val);
        @(posedge sys_clk);
        // Let the accepted request drop so a follow-up frame is not taken twice
        while (tx_valid === 1'b1) @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_basic;
        check(can_bitrate_sel, 3'h3);
        check(led_on, 1'b1);
        wr(REG_MASK, 32'h1);
        thumb_bcd <= 24'h123456;
        dil8 <= 8'hff;
        press();
        chk_tx(REQ_ID_BASE + 11'd7, 16'h5e26, 8'h02, 32'd123456);
        repeat (20) @(posedge sys_clk);
        check(irq, 1'b1);
        rd(REG_STATUS);
        check(d, 32'h1);
        wr(REG_STATUS, 32'h1);
        rd(8'h40);
        check(d, 32'h0);
        check(irq, 1'b0);
        mode <= 2'h2;
        wr(REG_CONTROL, 32'h1);
        chk_tx(REQ_ID_BASE + 11'd7, 16'h5e26, 8'h02, 32'd123456);
        repeat (8) @(posedge sys_clk);
        rd(REG_STATE);
        check(d[2:0], ERR_ABORT);
        press();
    endtask

    task automatic s_timeout;
        mode <= 2'h1;
        press();
        chk_tx(REQ_ID_BASE + 11'd7, 16'h5e26, 8'h02, 32'd123456);
        repeat (230) @(posedge sys_clk);
        rd(REG_STATE);
        check(d[2:0], ERR_TIMEOUT);
        lows = 0;
        repeat (40) @(posedge sys_clk) lows += (led_on === 1'b0);
        check(lows != 0, 1'b1);
        mode <= 2'h0;
        press();
        rd(REG_STATE);
        check(d[2:0], ERR_NONE);
        can_fault <= 1'b1;
        @(posedge sys_clk);
        rd(REG_STATE);
        can_fault <= 1'b0;
        check(d[2:0], ERR_BUS);
    endtask

    task automatic s_signed_store;
        do_reset(4'hc, 8'h3f, 1'b1);
        check(can_bitrate_sel, 3'h4);
        thumb_bcd <= 24'h912345;
        press();
        chk_tx(REQ_ID_BASE + 11'd31, 16'h5e26, 8'h01, 32'hffffcfc7);
        chk_tx(REQ_ID_BASE + 11'd31, STORE_INDEX, STORE_SUB, STORE_VALUE);
        repeat (20) @(posedge sys_clk);
        rd(REG_STATUS);
        check(d[2], 1'b1);
        thumb_bcd <= 24'h00000a;
        press();
        rd(REG_STATE);
        check(d[2:0], ERR_BCD);
    endtask

    task automatic s_config;
        do_reset(4'h7, 8'h00, 1'b0);
        press();
        rd(REG_STATE);
        check(d[2:0], ERR_CONFIG);
        check(tx_valid, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        do_reset(4'h3, 8'h47, 1'b0);
        s_basic();
        s_timeout();
        s_signed_store();
        s_config();
        give_verdict();
    end

    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end
endmodule
